/* common/telemetry_pkg.sv */
package telemetry_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int FRAME_TIME_MS = 20;
	localparam int FRAME_CYCLES = FRAME_TIME_MS * 1000000 / CLK_PERIOD_NS;
	localparam int SAMPLE_GAP_MS = 1;
	localparam int SAMPLE_GAP_CYCLES = (SAMPLE_GAP_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// word layout
	// ----------------------------------------------------------------
	localparam int WORD_BITS = 24;
	localparam int ID_BITS = 6;
	localparam int DATA_BITS = 18;
	localparam int BURST_BITS = 24;
	localparam int BLOCK_WORDS = 50;
	localparam logic [5:0] FIRST_ID = 6'h01;
	localparam logic [5:0] LAST_ID = 6'h32;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int ADR_BITS = 12;
	localparam logic [11:0] CTRL_OFS = 12'h000;
	localparam logic [11:0] STATUS_OFS = 12'h004;
	localparam logic [11:0] SHIFT_OFS = 12'h008;
	localparam logic [11:0] BLOCK_OFS = 12'h100;
	localparam int CTRL_EN_BIT = 0;
	localparam int STATUS_FLAG_BIT = 0;
	localparam int STATUS_REFUSED_BIT = 1;
	localparam int STATUS_ID_LSB = 8;
	localparam int STATUS_SLOT_LSB = 16;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic FLAG_RESET = 1'b1;

	typedef struct packed {
		logic [ID_BITS-1:0] id;
		logic [DATA_BITS-1:0] data;
	} tlm_word_t;

	typedef enum logic [2:0] {
		SEQ_OFF = 3'h1,
		SEQ_WAIT = 3'h2,
		SEQ_DONE = 3'h4
	} seq_state_t;

endpackage

/* hdl/bit_sync.sv */
`timescale 1ns/1ps
module bit_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk, // destination clock
	input wire logic resetn, // async reset, active low
	input wire logic [WIDTH-1:0] d, // foreign-domain level
	output logic [WIDTH-1:0] q // synchronised level
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule // bit_sync

/* hdl/telemetry_shifter.sv */
`timescale 1ns/1ps
module telemetry_shifter (
	input wire logic shift_clk, // shift pulse train
	input wire logic resetn, // async reset, active low
	input wire logic stop_pulse, // end-of-word marker, sampled on shift_clk
	input wire telemetry_pkg::tlm_word_t word, // word held stable by the loader
	output logic serial_out, // serial data, msb first
	output logic stop_toggle // flips once per stop pulse
);
	import telemetry_pkg::*;

	logic [4:0] pos;

	// ----------------------------------------------------------------
	// bit position, restarted by each stop pulse
	// ----------------------------------------------------------------
	always_ff @(posedge shift_clk or negedge resetn) begin
		if (!resetn) begin
			pos <= '0;
		end else if (stop_pulse) begin
			pos <= '0;
		end else if (pos != 5'(BURST_BITS)) begin
			pos <= pos + 5'h01;
		end
	end

	always_ff @(posedge shift_clk or negedge resetn) begin
		if (!resetn) begin
			stop_toggle <= 1'b0;
		end else if (stop_pulse) begin
			stop_toggle <= ~stop_toggle;
		end
	end

	// word only changes while the flag is set, i.e. between bursts
	assign serial_out = (pos < 5'(WORD_BITS)) ? word[5'(WORD_BITS - 1) - pos] : 1'b0;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	stop_rearm_a: assert property (@(posedge shift_clk) disable iff (!resetn)
		stop_pulse |=> pos == 5'h00 && serial_out == word[WORD_BITS-1])
		else $error("position not rearmed after stop pulse");
	shift_step_a: assert property (@(posedge shift_clk) disable iff (!resetn)
		!stop_pulse && pos < 5'(BURST_BITS) |=> pos == $past(pos) + 5'h01)
		else $error("shift did not advance one bit");
endmodule // telemetry_shifter

/* hdl/serial_telemetry_transmitter.sv */
// Our own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
module serial_telemetry_transmitter #(
	parameter int FRAME_CYC = telemetry_pkg::FRAME_CYCLES,
	parameter int SAMPLE_GAP_CYC = telemetry_pkg::SAMPLE_GAP_CYCLES
) (
	input wire logic mclk, // system clock, 10 MHz
	input wire logic resetn, // async reset, active low
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	input wire logic wb_we_i, // wishbone write
	input wire logic [telemetry_pkg::ADR_BITS-1:0] wb_adr_i, // byte address
	input wire logic [31:0] wb_dat_i, // write data
	input wire logic [3:0] wb_sel_i, // byte lanes
	output logic [31:0] wb_dat_o, // read data
	output logic wb_ack_o, // acknowledge
	input wire logic shift_clk, // link shift pulses
	input wire logic stop_pulse, // link end-of-word pulse
	output logic serial_out // link serial data
);
	import telemetry_pkg::*;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic in_block(input logic [ADR_BITS-1:0] adr);
		return adr >= BLOCK_OFS && adr < BLOCK_OFS + 12'(4 * BLOCK_WORDS);
	endfunction

	function automatic logic [5:0] block_index(input logic [ADR_BITS-1:0] adr);
		logic [ADR_BITS-1:0] rel;
		rel = adr - BLOCK_OFS;
		return rel[7:2];
	endfunction

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [31:0] ctrl;
	logic enable;
	logic done_flag;
	logic refused;
	tlm_word_t tword;
	tlm_word_t next_word;
	logic [DATA_BITS-1:0] block_mem [BLOCK_WORDS];
	logic [31:0] fcnt;
	logic [5:0] slot;
	seq_state_t state;
	logic frame_end;
	logic sample;
	logic hw_load;
	logic sw_req;
	logic sw_load;
	logic load;
	logic wb_hit;
	logic wb_wr;
	logic [31:0] rd_data;
	logic stop_tgl_link;
	logic stop_tgl_sync;
	logic stop_tgl_last;
	logic stop_set;

	assign enable = ctrl[CTRL_EN_BIT];
	assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wb_wr = wb_hit & wb_we_i;

	// ----------------------------------------------------------------
	// link side and crossing
	// ----------------------------------------------------------------
	telemetry_shifter u_shifter (
		.shift_clk(shift_clk),
		.resetn(resetn),
		.stop_pulse(stop_pulse),
		.word(tword),
		.serial_out(serial_out),
		.stop_toggle(stop_tgl_link)
	);

	bit_sync #(.WIDTH(1)) u_stop_sync (
		.clk(mclk),
		.resetn(resetn),
		.d(stop_tgl_link),
		.q(stop_tgl_sync)
	);

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			stop_tgl_last <= 1'b0;
		end else begin
			stop_tgl_last <= stop_tgl_sync;
		end
	end

	assign stop_set = stop_tgl_sync ^ stop_tgl_last;

	// ----------------------------------------------------------------
	// frame sequencer
	// ----------------------------------------------------------------
	assign frame_end = fcnt == 32'(FRAME_CYC - 1);
	assign sample = state == SEQ_WAIT && (fcnt == 32'h0 || fcnt == 32'(SAMPLE_GAP_CYC));
	assign hw_load = sample && done_flag;
	assign sw_req = wb_wr && wb_adr_i == SHIFT_OFS;
	assign sw_load = sw_req && done_flag && !hw_load;
	assign load = hw_load | sw_load;

	always_comb begin
		if (hw_load) begin
			next_word.id = slot + FIRST_ID;
			next_word.data = block_mem[slot];
		end else begin
			next_word = tlm_word_t'(WORD_BITS'(merge(32'(tword), wb_dat_i, wb_sel_i)));
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state <= SEQ_OFF;
		end else if (!enable) begin
			state <= SEQ_OFF;
		end else begin
			case (state)
				SEQ_OFF: state <= SEQ_WAIT;
				SEQ_WAIT: begin
					if (frame_end) begin
						state <= SEQ_WAIT;
					end else if (hw_load) begin
						state <= SEQ_DONE;
					end
				end
				SEQ_DONE: begin
					if (frame_end) begin
						state <= SEQ_WAIT;
					end
				end
				default: state <= SEQ_OFF;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			fcnt <= '0;
		end else if (state == SEQ_OFF || frame_end) begin
			fcnt <= '0;
		end else begin
			fcnt <= fcnt + 32'h1;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			slot <= '0;
		end else if (state == SEQ_OFF) begin
			slot <= '0;
		end else if (frame_end) begin
			slot <= (slot == 6'(BLOCK_WORDS - 1)) ? 6'h00 : slot + 6'h01;
		end
	end

	// ----------------------------------------------------------------
	// word register and word-done flag
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			tword <= '0;
		end else if (load) begin
			tword <= next_word;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			done_flag <= FLAG_RESET;
		end else if (stop_set) begin
			done_flag <= 1'b1;
		end else if (load) begin
			done_flag <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			refused <= 1'b0;
		end else if (sw_req && !sw_load) begin
			refused <= 1'b1;
		end else if (wb_wr && wb_adr_i == STATUS_OFS && wb_sel_i[0] && wb_dat_i[STATUS_REFUSED_BIT]) begin
			refused <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ctrl <= CTRL_RESET;
		end else if (wb_wr && wb_adr_i == CTRL_OFS) begin
			ctrl <= merge(ctrl, wb_dat_i, wb_sel_i) & 32'h0000_0001;
		end
	end

	always_ff @(posedge mclk) begin
		if (wb_wr && in_block(wb_adr_i)) begin
			block_mem[block_index(wb_adr_i)] <= DATA_BITS'(merge(32'(block_mem[block_index(wb_adr_i)]), wb_dat_i, wb_sel_i));
		end
	end

	always_comb begin
		rd_data = 32'h0;
		if (wb_adr_i == CTRL_OFS) begin
			rd_data = ctrl;
		end else if (wb_adr_i == STATUS_OFS) begin
			rd_data[STATUS_FLAG_BIT] = done_flag;
			rd_data[STATUS_REFUSED_BIT] = refused;
			rd_data[STATUS_ID_LSB +: ID_BITS] = tword.id;
			rd_data[STATUS_SLOT_LSB +: 6] = slot;
		end else if (in_block(wb_adr_i)) begin
			rd_data = 32'(block_mem[block_index(wb_adr_i)]);
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_hit;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			wb_dat_o <= 32'h0;
		end else if (wb_hit && !wb_we_i) begin
			wb_dat_o <= rd_data;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic [1:0] loads_in_frame;
	logic [31:0] since_sample;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			loads_in_frame <= 2'h0;
		end else if (frame_end || state == SEQ_OFF) begin
			loads_in_frame <= 2'h0;
		end else if (hw_load && loads_in_frame != 2'h3) begin
			loads_in_frame <= loads_in_frame + 2'h1;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			since_sample <= 32'hffff_ffff;
		end else if (sample) begin
			since_sample <= 32'h1; // cycles since the last sample, counted from its edge
		end else if (since_sample != 32'hffff_ffff) begin
			since_sample <= since_sample + 32'h1;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	load_needs_flag_a: assert property (!done_flag |=> tword == $past(tword))
		else $error("load while word-done flag clear");
	load_clears_flag_a: assert property (load && !stop_set |=> !done_flag)
		else $error("flag not cleared by load");
	stop_sets_flag_a: assert property ($changed(stop_tgl_sync) |=> done_flag)
		else $error("stop pulse did not set flag");
	one_load_frame_a: assert property (loads_in_frame <= 2'h1)
		else $error("more than one load in a frame");
	sample_spacing_a: assert property (sample && fcnt != 32'h0 |-> since_sample >= 32'(SAMPLE_GAP_CYC))
		else $error("flag samples too close");
	word_format_a: assert property (hw_load |=> tword.id == $past(slot) + FIRST_ID
		&& tword.data == $past(block_mem[slot]))
		else $error("word not built from id and memory word");
	id_range_a: assert property (hw_load |-> next_word.id >= FIRST_ID && next_word.id <= LAST_ID)
		else $error("identifier out of range");
	block_wrap_a: assert property (frame_end && slot == 6'(BLOCK_WORDS - 1) && enable |=> slot == 6'h00)
		else $error("block did not restart at word one");
	flag_holds_a: assert property (!done_flag && !stop_set |=> !done_flag)
		else $error("flag set without stop pulse");

	load_seen_c: cover property (hw_load);
	late_sample_c: cover property (hw_load && fcnt == 32'(SAMPLE_GAP_CYC));
	block_wrap_c: cover property (frame_end && slot == 6'(BLOCK_WORDS - 1));
	refused_c: cover property (sw_req && !sw_load);
endmodule // serial_telemetry_transmitter

/* test/telemetry_source.sv */
`timescale 1ns/1ps
module telemetry_source (
	input wire logic start, // begin one burst
	input wire logic serial_out, // transmitter serial data
	output logic shift_clk, // shift pulses, still between bursts
	output logic stop_pulse, // end-of-word marker
	output logic [23:0] captured, // word seen on the wire, msb first
	output logic busy // burst in progress
);
	// ----------------------------------------------------------------
	// one burst: 24 shifts then a stop edge, 80 ns pulse period
	// ----------------------------------------------------------------
	initial begin
		shift_clk = 1'b0;
		stop_pulse = 1'b0;
		captured = 24'h0;
		busy = 1'b0;
	end

	// data is sampled at the end of each bit, just before the next shifting edge
	always @(posedge start) begin
		busy = 1'b1;
		#13;
		for (int i = 0; i < 24; i++) begin
			#40;
			captured = {captured[22:0], serial_out};
			shift_clk = 1'b1;
			#40;
			shift_clk = 1'b0;
		end
		stop_pulse = 1'b1;
		#40;
		shift_clk = 1'b1;
		#40;
		shift_clk = 1'b0;
		#20;
		stop_pulse = 1'b0;
		busy = 1'b0;
	end
endmodule // telemetry_source

/* test/tb.sv */
`timescale 1ns/1ps
module tb;
	import telemetry_pkg::*;
	// ----------------------------------------------------------------
	// signals and instances
	// ----------------------------------------------------------------
	logic mclk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, shift_clk, stop_pulse, serial_out, start, busy;
	logic [11:0] wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic [3:0] wb_sel_i;
	logic [23:0] captured, w1;
	int num_errors, cmp_count, s;

	serial_telemetry_transmitter #(.FRAME_CYC(400), .SAMPLE_GAP_CYC(100)) dut_u (.mclk(mclk), .resetn(resetn),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
		.wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .shift_clk(shift_clk),
		.stop_pulse(stop_pulse), .serial_out(serial_out));
	telemetry_source src_u (.start(start), .serial_out(serial_out), .shift_clk(shift_clk),
		.stop_pulse(stop_pulse), .captured(captured), .busy(busy));

	always #50 mclk = ~mclk;

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic report_and_stop;
		if (num_errors == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			$display("unexpected %s expected %h seen %h", name, exp, got);
			num_errors++;
		end
	endtask

	task automatic timeout(input string name);
		$display("unexpected %s expected done seen timeout", name);
		num_errors++;
		report_and_stop;
	endtask

	task automatic wb_cycle(input logic [11:0] a, input logic we, input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge mclk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hf;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (wb_ack_o !== 1'b1) timeout("bus ack");
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask

	task automatic wait_flag(input logic v);
		int n;
		n = 0;
		do begin
			wb_cycle(STATUS_OFS, 1'b0, 32'h0, rd);
			n++;
		end while (rd[STATUS_FLAG_BIT] !== v && n < 400);
		if (rd[STATUS_FLAG_BIT] !== v) timeout("word-done flag");
	endtask

	task automatic run_burst;
		int n;
		start <= 1'b1;
		@(posedge mclk);
		start <= 1'b0;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (busy === 1'b1 && n < 100);
		if (busy === 1'b1) timeout("burst");
	endtask

	function automatic logic [17:0] mem_val(input int i);
		return 18'(i * 18'h00b35) ^ ((i % 2 == 1) ? 18'h20000 : 18'h0);
	endfunction

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		resetn = 1'b0;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 12'h000;
		wb_dat_i = 32'h0;
		wb_sel_i = 4'h0;
		start = 1'b0;
		num_errors = 0;
		cmp_count = 0;
		w1 = {6'h2a, 18'h25a5c};
		repeat (4) @(posedge mclk);
		resetn <= 1'b1;
		wb_cycle(CTRL_OFS, 1'b0, 32'h0, rd);
		check("ctrl reset", rd, CTRL_RESET);
		wb_cycle(STATUS_OFS, 1'b0, 32'h0, rd);
		check("flag reset", 32'(rd[STATUS_FLAG_BIT]), 32'(FLAG_RESET));
		wb_cycle(12'hff0, 1'b1, 32'hffff_ffff, rd);
		wb_cycle(12'hff0, 1'b0, 32'h0, rd);
		check("unmapped read", rd, 32'h0);
		for (int i = 0; i < BLOCK_WORDS; i++) begin
			wb_cycle(BLOCK_OFS + 12'(4 * i), 1'b1, 32'(mem_val(i)), rd);
		end
		wb_cycle(BLOCK_OFS + 12'h01c, 1'b0, 32'h0, rd);
		check("block word", rd & 32'h3ffff, 32'(mem_val(7)));
		// direct load, refused reload, then shift out
		wb_cycle(SHIFT_OFS, 1'b1, 32'(w1), rd);
		wb_cycle(STATUS_OFS, 1'b0, 32'h0, rd);
		check("flag after load", 32'(rd[1:0]), 32'h0);
		check("status id", 32'(rd[13:8]), 32'h2a);
		check("msb on output", 32'(serial_out), 32'(w1[23]));
		wb_cycle(SHIFT_OFS, 1'b1, 32'(~w1), rd);
		wb_cycle(STATUS_OFS, 1'b0, 32'h0, rd);
		check("refused load", 32'(rd[1:0]), 32'h2);
		run_burst;
		check("serial word", 32'(captured), 32'(w1));
		wait_flag(1'b1);
		wb_cycle(STATUS_OFS, 1'b1, 32'h2, rd);
		wb_cycle(STATUS_OFS, 1'b0, 32'h0, rd);
		check("refused cleared", 32'(rd[1:0]), 32'h1);
		// sequencer frames, past one wrap of the block
		wb_cycle(CTRL_OFS, 1'b1, 32'h1, rd);
		s = 0;
		for (int f = 0; f < 55; f++) begin
			wait_flag(1'b0);
			wb_cycle(STATUS_OFS, 1'b0, 32'h0, rd);
			check("frame id", 32'(rd[13:8]), 32'(s + 1));
			check("frame slot", 32'(rd[21:16]), 32'(s));
			// late flag: only the second sample of the next frame can load
			if (f == 20) repeat (400) @(posedge mclk);
			run_burst;
			check("frame word", 32'(captured), {8'h0, 6'(s + 1), mem_val(s)});
			wait_flag(1'b1);
			s = (s + 1) % BLOCK_WORDS;
		end
		// stopping the sequencer sends it back to the first word
		wb_cycle(CTRL_OFS, 1'b1, 32'h0, rd);
		wb_cycle(STATUS_OFS, 1'b0, 32'h0, rd);
		check("slot after stop", 32'(rd[21:16]), 32'h0);
		report_and_stop;
	end
endmodule // tb
